// ==== rtl/bcc_pkg.sv ====
// bcc_pkg: constants, types and register map of the backup cache coherency controller
// assumes a 32-bit processor register address space and 32-bit memory-bus addresses
package bcc_pkg;
    localparam int TAG_W = 12;
    localparam int IDX_W = 12;
    localparam int ENTRIES = 4096;
    localparam int TAG_LSB = 17;
    localparam int IDX_LSB = 5;
    localparam int QW_LSB = 3;
    localparam int IO_BIT = 29;
    localparam int GRP_BIT = 24;
    localparam int DEALLOC_BIT = 22;
    localparam logic [7:0] REG_CACHE_CONTROL = 8'hA0;
    localparam logic [7:0] REG_DATA_CHECK_BITS = 8'hA2;
    localparam logic [7:0] REG_TAG_ERROR_STATUS = 8'hA3;
    localparam logic [7:0] REG_TAG_ERROR_INDEX = 8'hA4;
    localparam logic [7:0] REG_TAG_ERROR_VALUE = 8'hA5;
    localparam logic [7:0] REG_DATA_ERROR_STATUS = 8'hA6;
    localparam logic [7:0] REG_DATA_ERROR_INDEX = 8'hA7;
    localparam logic [7:0] REG_DATA_ERROR_SYNDROME = 8'hA8;
    localparam logic [7:0] REG_FILL_ERROR_ADDRESS = 8'hAB;
    localparam logic [7:0] REG_FILL_ERROR_STATUS = 8'hAC;
    localparam logic [7:0] REG_BUS_ERROR_STATUS = 8'hAE;
    localparam logic [7:0] REG_BUS_ERROR_OUT_ADDRESS = 8'hB0;
    localparam logic [7:0] REG_BUS_ERROR_OUT_COMMAND = 8'hB2;
    localparam logic [7:0] REG_BUS_ERROR_DATA_HIGH = 8'hB4;
    localparam logic [7:0] REG_BUS_ERROR_DATA_LOW = 8'hB6;
    localparam logic [7:0] REG_BUS_ERROR_IN_COMMAND = 8'hB8;
    localparam logic [7:0] REG_INTERNAL_FIRST = 8'hA0;
    localparam logic [7:0] REG_INTERNAL_LAST = 8'hBF;
    localparam logic [31:0] TAG_DIRECT_ACCESS_BASE = 32'h0100_0000;
    localparam logic [31:0] BLOCK_DEALLOCATE_BASE = 32'h0140_0000;
    localparam logic [31:0] IO_MERGE_MASK = 32'hE100_0000;
    localparam logic [31:0] CACHE_CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] CACHE_CONTROL_MASK = 32'hC001_07FF;
    localparam int CC_ENABLE = 0;
    localparam int CC_FORCE_HIT = 6;
    localparam int TAGREG_VALID = 30;
    localparam int TAGREG_OWNED = 31;

    typedef enum logic [2:0] {
        BCC_CMD_READ_HEXA,
        BCC_CMD_OWN_READ,
        BCC_CMD_DISOWN_WRITE,
        BCC_CMD_READ_QW,
        BCC_CMD_WRITE_QW,
        BCC_CMD_IO_READ,
        BCC_CMD_IO_WRITE
    } bcc_cmd_t;

    typedef struct packed {
        bcc_cmd_t cmd;
        logic [31:0] addr;
    } bcc_mem_cmd_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic [31:0] addr;
    } bcc_ref_t;
endpackage

// ==== rtl/bcc_ctrl.sv ====
// bcc_ctrl: tag store, allocation, snoop and processor register decode of the backup cache
// assumes all requesters run on sys_clk_i and hold their request until the matching done pulse
`timescale 1ns/1ps
// Contract
// - 12-bit tag, 12-bit index, bits 2..0 unused
// - bits 4..3 select quadword, not tags
// - read miss issues one hexaword read
// - allocate before miss read, fill both
// - owned valid victim disown-written before fill
// - direct mapped: index picks the block
// - writes allocate; direct only when disabled
// - owned write hit: no bus cycle
// - absent or unowned write: ownership read first
// - primary cache never allocated on writes
// - snoop every DMA; miss does nothing
// - DMA write unowned hit invalidates both
// - DMA owned hit: disown write back
// - bit 24 clear: 256 ordinary registers
// - 4K tag registers from 01000000, step 20
// - 4K write-only deallocate registers invalidate block
// - ignore bits 4..0 and unused bits
// - tag/deallocate and A0..BF internal; others become I/O
// - unimplemented reads undefined, writes discarded
// - outside block: force 31..29, 24
// - cache disabled: every reference misses
// - tag, valid, owned kept per block
module bcc_ctrl
    import bcc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire bcc_ref_t cpu_ref_i,
    input wire bcc_ref_t dma_ref_i,
    input wire bcc_ref_t reg_ref_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    output logic cpu_done_o,
    output logic cpu_hit_o,
    output logic [1:0] qw_sel_o,
    output logic cache_fill_o,
    output logic cache_write_o,
    output logic dma_done_o,
    output logic pc_inval_o,
    output logic [31:0] pc_inval_addr_o,
    output logic reg_done_o,
    output logic [31:0] reg_rdata_o,
    output logic mem_req_o,
    output bcc_mem_cmd_t mem_cmd_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_VICTIM, ST_FILL, ST_OREAD, ST_IO, ST_SNOOP_WB, ST_FLUSH_WB} bcc_state_t;

    bcc_state_t state_r, state_nxt;
    logic [ENTRIES-1:0] valid_r, valid_nxt, owned_r, owned_nxt;
    logic [TAG_W-1:0] tag_mem [ENTRIES];
    logic tag_we;
    logic [IDX_W-1:0] tag_widx;
    logic [TAG_W-1:0] tag_wdata;
    logic [31:0] cache_control_r, cache_control_nxt, addr_r, addr_nxt, rdata_r, rdata_nxt, pc_addr_r, pc_addr_nxt;
    logic we_r, we_nxt, io_for_reg_r, io_for_reg_nxt;
    logic cpu_done_r, cpu_done_nxt, hit_r, hit_nxt, fill_r, fill_nxt, wr_r, wr_nxt;
    logic dma_done_r, dma_done_nxt, pc_inv_r, pc_inv_nxt, reg_done_r, reg_done_nxt;
    logic mem_req_r, mem_req_nxt;
    bcc_mem_cmd_t mcmd_r, mcmd_nxt;
    logic [1:0] qw_r, qw_nxt;
    logic [31:0] look;
    logic [IDX_W-1:0] lidx;
    logic [TAG_W-1:0] ltag, stag;
    logic hit, en;

    function automatic logic [31:0] hexa_addr(input logic [TAG_W-1:0] t, input logic [IDX_W-1:0] i);
        return {3'h0, t, i, 5'h00};
    endfunction

    always_comb begin
        if (state_r != ST_IDLE) look = addr_r;
        else if (dma_ref_i.valid && !dma_done_r) look = dma_ref_i.addr;
        else if (reg_ref_i.valid && !reg_done_r) look = {15'h0000, reg_ref_i.addr[16:0]};
        else look = cpu_ref_i.addr;
        lidx = look[IDX_LSB +: IDX_W];
        ltag = look[TAG_LSB +: TAG_W];
        stag = tag_mem[lidx];
        en = cache_control_r[CC_ENABLE];
        hit = en && valid_r[lidx] && (stag == ltag);
    end

    always_comb begin
        state_nxt = state_r;
        valid_nxt = valid_r;
        owned_nxt = owned_r;
        cache_control_nxt = cache_control_r;
        addr_nxt = addr_r;
        we_nxt = we_r;
        io_for_reg_nxt = io_for_reg_r;
        rdata_nxt = rdata_r;
        pc_addr_nxt = pc_addr_r;
        qw_nxt = qw_r;
        hit_nxt = hit_r;
        mem_req_nxt = mem_req_r;
        mcmd_nxt = mcmd_r;
        cpu_done_nxt = 1'b0;
        fill_nxt = 1'b0;
        wr_nxt = 1'b0;
        dma_done_nxt = 1'b0;
        pc_inv_nxt = 1'b0;
        reg_done_nxt = 1'b0;
        tag_we = 1'b0;
        tag_widx = lidx;
        tag_wdata = ltag;
        if (mem_req_r && mem_ack_i) mem_req_nxt = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                addr_nxt = look;
                if (dma_ref_i.valid && !dma_done_r) begin
                    we_nxt = dma_ref_i.we;
                    if (hit && owned_r[lidx]) begin
                        mem_req_nxt = 1'b1;
                        mcmd_nxt = '{BCC_CMD_DISOWN_WRITE, hexa_addr(stag, lidx)};
                        state_nxt = ST_SNOOP_WB;
                    end else if (hit && dma_ref_i.we) begin
                        valid_nxt[lidx] = 1'b0;
                        pc_inv_nxt = 1'b1;
                        pc_addr_nxt = hexa_addr(ltag, lidx);
                        dma_done_nxt = 1'b1;
                    end else begin
                        dma_done_nxt = 1'b1;
                    end
                end else if (reg_ref_i.valid && !reg_done_r) begin
                    we_nxt = reg_ref_i.we;
                    if (reg_ref_i.addr[GRP_BIT] && !reg_ref_i.addr[DEALLOC_BIT]) begin
                        if (reg_ref_i.we) begin
                            tag_we = 1'b1;
                            tag_wdata = reg_wdata_i[TAG_W-1:0];
                            valid_nxt[lidx] = reg_wdata_i[TAGREG_VALID];
                            owned_nxt[lidx] = reg_wdata_i[TAGREG_OWNED];
                        end
                        rdata_nxt = {owned_r[lidx], valid_r[lidx], 18'h00000, stag};
                        reg_done_nxt = 1'b1;
                    end else if (reg_ref_i.addr[GRP_BIT]) begin
                        if (reg_ref_i.we && valid_r[lidx] && owned_r[lidx]) begin
                            mem_req_nxt = 1'b1;
                            mcmd_nxt = '{BCC_CMD_DISOWN_WRITE, hexa_addr(stag, lidx)};
                            state_nxt = ST_FLUSH_WB;
                        end else begin
                            if (reg_ref_i.we && valid_r[lidx]) begin
                                valid_nxt[lidx] = 1'b0;
                                pc_inv_nxt = 1'b1;
                                pc_addr_nxt = hexa_addr(stag, lidx);
                            end
                            rdata_nxt = 32'h0000_0000;
                            reg_done_nxt = 1'b1;
                        end
                    end else if (reg_ref_i.addr[7:0] >= REG_INTERNAL_FIRST &&
                                 reg_ref_i.addr[7:0] <= REG_INTERNAL_LAST) begin
                        if (reg_ref_i.addr[7:0] == REG_CACHE_CONTROL) begin
                            if (reg_ref_i.we) cache_control_nxt = reg_wdata_i & CACHE_CONTROL_MASK;
                            rdata_nxt = cache_control_r;
                        end else begin
                            rdata_nxt = 32'h0000_0000;
                        end
                        reg_done_nxt = 1'b1;
                    end else begin
                        io_for_reg_nxt = 1'b1;
                        mem_req_nxt = 1'b1;
                        mcmd_nxt = '{reg_ref_i.we ? BCC_CMD_IO_WRITE : BCC_CMD_IO_READ,
                                     reg_ref_i.addr | IO_MERGE_MASK};
                        state_nxt = ST_IO;
                    end
                end else if (cpu_ref_i.valid && !cpu_done_r) begin
                    we_nxt = cpu_ref_i.we;
                    qw_nxt = cpu_ref_i.addr[QW_LSB +: 2];
                    io_for_reg_nxt = 1'b0;
                    if (cpu_ref_i.addr[IO_BIT] || !en) begin
                        mem_req_nxt = 1'b1;
                        mcmd_nxt = '{cpu_ref_i.addr[IO_BIT] ? (cpu_ref_i.we ? BCC_CMD_IO_WRITE : BCC_CMD_IO_READ)
                                     : (cpu_ref_i.we ? BCC_CMD_WRITE_QW : BCC_CMD_READ_QW), cpu_ref_i.addr};
                        hit_nxt = 1'b0;
                        state_nxt = ST_IO;
                    end else if (cache_control_r[CC_FORCE_HIT] || (hit && (!cpu_ref_i.we || owned_r[lidx]))) begin
                        hit_nxt = 1'b1;
                        cpu_done_nxt = 1'b1;
                        fill_nxt = !cpu_ref_i.we;
                        wr_nxt = cpu_ref_i.we;
                    end else begin
                        hit_nxt = 1'b0;
                        if (valid_r[lidx] && owned_r[lidx] && stag != ltag) begin
                            mem_req_nxt = 1'b1;
                            mcmd_nxt = '{BCC_CMD_DISOWN_WRITE, hexa_addr(stag, lidx)};
                            state_nxt = ST_VICTIM;
                        end else if (cpu_ref_i.we) begin
                            mem_req_nxt = 1'b1;
                            mcmd_nxt = '{BCC_CMD_OWN_READ, hexa_addr(ltag, lidx)};
                            state_nxt = ST_OREAD;
                        end else begin
                            tag_we = 1'b1;
                            valid_nxt[lidx] = 1'b0;
                            owned_nxt[lidx] = 1'b0;
                            mem_req_nxt = 1'b1;
                            mcmd_nxt = '{BCC_CMD_READ_HEXA, hexa_addr(ltag, lidx)};
                            state_nxt = ST_FILL;
                        end
                    end
                end
            end
            ST_VICTIM: if (mem_ack_i) begin
                mem_req_nxt = 1'b1;
                valid_nxt[lidx] = 1'b0;
                owned_nxt[lidx] = 1'b0;
                pc_inv_nxt = 1'b1;
                pc_addr_nxt = hexa_addr(stag, lidx);
                if (we_r) begin
                    mcmd_nxt = '{BCC_CMD_OWN_READ, hexa_addr(ltag, lidx)};
                    state_nxt = ST_OREAD;
                end else begin
                    tag_we = 1'b1;
                    mcmd_nxt = '{BCC_CMD_READ_HEXA, hexa_addr(ltag, lidx)};
                    state_nxt = ST_FILL;
                end
            end
            ST_FILL: if (mem_ack_i) begin
                valid_nxt[lidx] = 1'b1;
                fill_nxt = 1'b1;
                cpu_done_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            ST_OREAD: if (mem_ack_i) begin
                tag_we = 1'b1;
                valid_nxt[lidx] = 1'b1;
                owned_nxt[lidx] = 1'b1;
                wr_nxt = 1'b1;
                cpu_done_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            ST_IO: if (mem_ack_i) begin
                rdata_nxt = mem_rdata_i;
                reg_done_nxt = io_for_reg_r;
                cpu_done_nxt = !io_for_reg_r;
                io_for_reg_nxt = 1'b0;
                state_nxt = ST_IDLE;
            end
            ST_SNOOP_WB, ST_FLUSH_WB: if (mem_ack_i) begin
                valid_nxt[lidx] = 1'b0;
                owned_nxt[lidx] = 1'b0;
                pc_inv_nxt = 1'b1;
                pc_addr_nxt = hexa_addr(stag, lidx);
                dma_done_nxt = (state_r == ST_SNOOP_WB);
                reg_done_nxt = (state_r == ST_FLUSH_WB);
                rdata_nxt = 32'h0000_0000;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (tag_we) tag_mem[tag_widx] <= tag_wdata;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            valid_r <= '0;
            owned_r <= '0;
            cache_control_r <= CACHE_CONTROL_RST;
            addr_r <= 32'h0000_0000;
            we_r <= 1'b0;
            io_for_reg_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            pc_addr_r <= 32'h0000_0000;
            qw_r <= 2'h0;
            hit_r <= 1'b0;
            mem_req_r <= 1'b0;
            mcmd_r <= '{BCC_CMD_READ_HEXA, 32'h0000_0000};
            cpu_done_r <= 1'b0;
            fill_r <= 1'b0;
            wr_r <= 1'b0;
            dma_done_r <= 1'b0;
            pc_inv_r <= 1'b0;
            reg_done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            valid_r <= valid_nxt;
            owned_r <= owned_nxt;
            cache_control_r <= cache_control_nxt;
            addr_r <= addr_nxt;
            we_r <= we_nxt;
            io_for_reg_r <= io_for_reg_nxt;
            rdata_r <= rdata_nxt;
            pc_addr_r <= pc_addr_nxt;
            qw_r <= qw_nxt;
            hit_r <= hit_nxt;
            mem_req_r <= mem_req_nxt;
            mcmd_r <= mcmd_nxt;
            cpu_done_r <= cpu_done_nxt;
            fill_r <= fill_nxt;
            wr_r <= wr_nxt;
            dma_done_r <= dma_done_nxt;
            pc_inv_r <= pc_inv_nxt;
            reg_done_r <= reg_done_nxt;
        end
    end

    assign cpu_done_o = cpu_done_r;
    assign cpu_hit_o = hit_r;
    assign qw_sel_o = qw_r;
    assign cache_fill_o = fill_r;
    assign cache_write_o = wr_r;
    assign dma_done_o = dma_done_r;
    assign pc_inval_o = pc_inv_r;
    assign pc_inval_addr_o = pc_addr_r;
    assign reg_done_o = reg_done_r;
    assign reg_rdata_o = rdata_r;
    assign mem_req_o = mem_req_r;
    assign mem_cmd_o = mcmd_r;

    a_fill_is_hexa: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(mem_req_o) && state_r == ST_FILL |-> mem_cmd_o.cmd == BCC_CMD_READ_HEXA && mem_cmd_o.addr[4:0] == 5'h00)
        else $error("fill read is not a hexaword read");
    a_victim_first: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_r == ST_VICTIM |-> mem_cmd_o.cmd == BCC_CMD_DISOWN_WRITE)
        else $error("victim not written back by disown write");
    a_owned_hit_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cache_write_o && cpu_hit_o |-> $past(state_r) == ST_IDLE && !$past(mem_req_o, 1) ##0 !$rose(mem_req_o))
        else $error("owned write hit caused a bus cycle");
    a_write_no_fill: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cache_fill_o |-> !cache_write_o && !we_r)
        else $error("write allocated the primary cache");
    a_oread_owns: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_r == ST_OREAD && mem_ack_i |=> owned_r[addr_r[IDX_LSB +: IDX_W]] && cpu_done_o)
        else $error("ownership read did not set owned");
    a_snoop_disown: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_r == ST_SNOOP_WB && mem_ack_i |=> dma_done_o && pc_inval_o)
        else $error("owned snoop hit not completed");
    a_io_merge: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_r == ST_IO && io_for_reg_r |-> (mem_cmd_o.addr & IO_MERGE_MASK) == IO_MERGE_MASK)
        else $error("register I/O address not merged");
    a_disabled_miss: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !cache_control_r[CC_ENABLE] && cpu_done_o |-> !cpu_hit_o)
        else $error("hit reported with cache disabled");
    a_done_bounded: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_r == ST_IDLE && dma_ref_i.valid && !dma_done_r && !hit |=> dma_done_o)
        else $error("snoop miss not answered in one cycle");
    c_read_fill: cover property (@(posedge sys_clk_i) disable iff (rst_i) state_r == ST_FILL ##[1:50] cache_fill_o);
    c_victim_oread: cover property (@(posedge sys_clk_i) disable iff (rst_i) state_r == ST_VICTIM ##[1:50] state_r == ST_OREAD);
    c_snoop_wb: cover property (@(posedge sys_clk_i) disable iff (rst_i) state_r == ST_SNOOP_WB ##[1:50] dma_done_o);
    c_flush: cover property (@(posedge sys_clk_i) disable iff (rst_i) state_r == ST_FLUSH_WB ##[1:50] reg_done_o);
endmodule // bcc_ctrl

// ==== dv/bcc_mem_model.sv ====
// bcc_mem_model: memory controller on the far side of the backup cache bus
// assumes one request at a time, held by the device until one ack pulse
`timescale 1ns/1ps
module bcc_mem_model
    import bcc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic mem_req_i,
    input wire bcc_mem_cmd_t mem_cmd_i,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o
);
    int delay = 0;
    int cnt = 0;
    bcc_mem_cmd_t log[$];
    initial mem_ack_o = 1'b0;
    initial mem_rdata_o = 32'h0000_0000;
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            mem_ack_o <= 1'b0;
            cnt <= 0;
        end else if (mem_ack_o) begin
            mem_ack_o <= 1'b0;
            cnt <= 0;
            mem_rdata_o <= ~mem_rdata_o;
        end else if (mem_req_i === 1'b1 && cnt >= delay) begin
            // disown write lands in memory before a pended dma may finish
            mem_ack_o <= 1'b1;
            mem_rdata_o <= {16'hDA7A, mem_cmd_i.addr[15:0]};
            log.push_back(mem_cmd_i);
        end else begin
            cnt <= (mem_req_i === 1'b1) ? cnt + 1 : 0;
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule // bcc_mem_model

// ==== dv/testbench.sv ====
// testbench: scenario tasks for the backup cache controller
// assumes requests held until done and the memory model answering the bus
`timescale 1ns/1ps
module testbench
    import bcc_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    bcc_ref_t cpu_ref = '0;
    bcc_ref_t dma_ref = '0;
    bcc_ref_t reg_ref = '0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic mem_ack, cpu_done, cpu_hit, fill, cwr, dma_done, pc_inval, reg_done, mem_req;
    logic [1:0] qw_sel;
    logic [31:0] inval_addr, reg_rdata, mem_rdata;
    bcc_mem_cmd_t mem_cmd;
    int error_cnt = 0;
    int checks = 0;
    logic fill_s, wr_s, inv_s, hit_v;
    logic [31:0] rd_v;
    localparam logic [31:0] TAGR = 32'h0100_0000;
    localparam logic [31:0] DEAL = 32'h0140_0000;
    always #4 sys_clk_i = ~sys_clk_i;
    bcc_ctrl uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cpu_ref_i(cpu_ref), .dma_ref_i(dma_ref),
        .reg_ref_i(reg_ref), .reg_wdata_i(reg_wdata), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
        .cpu_done_o(cpu_done), .cpu_hit_o(cpu_hit), .qw_sel_o(qw_sel), .cache_fill_o(fill),
        .cache_write_o(cwr), .dma_done_o(dma_done), .pc_inval_o(pc_inval),
        .pc_inval_addr_o(inval_addr), .reg_done_o(reg_done), .reg_rdata_o(reg_rdata),
        .mem_req_o(mem_req), .mem_cmd_o(mem_cmd));
    bcc_mem_model mem (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .mem_req_i(mem_req),
        .mem_cmd_i(mem_cmd), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));
    function automatic logic [31:0] mk(input logic [11:0] t, input logic [11:0] i);
        return {3'b000, t, i, 5'b00000};
    endfunction
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // port 0 cpu, 1 dma, 2 register; pulses seen up to done are collected
    task automatic xfer(input int p, input logic we, input logic [31:0] a, input logic [31:0] wd);
        bcc_ref_t r;
        logic dn;
        r = '{valid: 1'b1, we: we, addr: a};
        {fill_s, wr_s, inv_s, dn} = 4'h0;
        mem.log.delete();
        @(posedge sys_clk_i);
        if (p == 0) cpu_ref <= r;
        else if (p == 1) dma_ref <= r;
        else begin
            reg_ref <= r;
            reg_wdata <= wd;
        end
        for (int n = 0; n < 300 && !dn; n++) begin
            @(posedge sys_clk_i);
            #1;
            fill_s |= (fill === 1'b1);
            wr_s |= (cwr === 1'b1);
            inv_s |= (pc_inval === 1'b1);
            dn = ((p == 0) ? cpu_done : (p == 1) ? dma_done : reg_done) === 1'b1;
        end
        hit_v = cpu_hit;
        rd_v = reg_rdata;
        if (!dn) begin
            error_cnt++;
            print_verdict();
        end
        @(posedge sys_clk_i);
        cpu_ref <= '0;
        dma_ref <= '0;
        reg_ref <= '0;
    endtask
    task automatic ops(input int n);
        chk("bus ops", mem.log.size(), n);
    endtask
    task automatic op(input int k, input bcc_cmd_t c, input logic [31:0] a);
        chk("bus op", mem.log[k], {c, a});
    endtask
    task automatic t_disabled();
        xfer(0, 0, mk(12'h003, 12'h005) + 8, 0);
        chk("rd cmd", mem.log[0].cmd, BCC_CMD_READ_QW);
        chk("hit", hit_v, 0);
        xfer(0, 1, mk(12'h003, 12'h005), 0);
        chk("wr cmd", mem.log[0].cmd, BCC_CMD_WRITE_QW);
    endtask
    task automatic t_control();
        xfer(2, 0, 32'h0000_00A0, 0);
        chk("ctl rst", rd_v, CACHE_CONTROL_RST);
        xfer(2, 1, 32'h0000_00A0, 32'hFFFF_FFFF);
        xfer(0, 1, mk(12'h00A, 12'h00A), 0);
        ops(0);
        chk("force hit", {hit_v, wr_s}, 2'h3);
        xfer(2, 0, 32'h0000_00A0, 0);
        chk("ctl mask", rd_v, CACHE_CONTROL_MASK);
        xfer(2, 1, 32'h0000_00A0, 32'h0000_0001);
        xfer(2, 1, 32'h0000_00A1, 32'hFFFF_FFFF);
        ops(0);
        xfer(2, 0, 32'h0000_00A0, 0);
        chk("ctl kept", rd_v, 32'h0000_0001);
    endtask
    task automatic t_fill();
        xfer(0, 0, mk(12'h003, 12'h005) + 8, 0);
        ops(1);
        op(0, BCC_CMD_READ_HEXA, mk(12'h003, 12'h005));
        chk("miss fill", {hit_v, fill_s, qw_sel}, 4'h5);
        xfer(0, 0, mk(12'h003, 12'h005) + 24, 0);
        ops(0);
        chk("hit fill", {hit_v, qw_sel}, 3'h7);
        xfer(0, 1, mk(12'h003, 12'h005), 0);
        op(0, BCC_CMD_OWN_READ, mk(12'h003, 12'h005));
        chk("own wr", {wr_s, fill_s}, 2'h2);
        xfer(0, 1, mk(12'h003, 12'h005) + 16, 0);
        ops(0);
        chk("owned wr", {hit_v, wr_s}, 2'h3);
        xfer(0, 0, mk(12'h003, 12'h005) + 16, 0);
        chk("rd after wr", {hit_v, fill_s, wr_s}, 3'h6);
    endtask
    task automatic t_victim();
        xfer(0, 0, mk(12'h007, 12'h005), 0);
        ops(2);
        op(0, BCC_CMD_DISOWN_WRITE, mk(12'h003, 12'h005));
        op(1, BCC_CMD_READ_HEXA, mk(12'h007, 12'h005));
        chk("victim inval", inv_s, 1);
        chk("victim addr", inval_addr, mk(12'h003, 12'h005));
    endtask
    task automatic t_dma();
        xfer(1, 0, mk(12'h007, 12'h005), 0);
        chk("dma rd", {mem.log.size() == 0, inv_s}, 2'h2);
        xfer(1, 1, mk(12'h003, 12'h005), 0);
        chk("dma miss", {mem.log.size() == 0, inv_s}, 2'h2);
        xfer(1, 1, mk(12'h007, 12'h005), 0);
        chk("dma wr", {mem.log.size() == 0, inv_s}, 2'h3);
        chk("dma inval addr", inval_addr, mk(12'h007, 12'h005));
        xfer(0, 1, mk(12'h007, 12'h005), 0);
        op(0, BCC_CMD_OWN_READ, mk(12'h007, 12'h005));
        xfer(1, 0, mk(12'h007, 12'h005) + 8, 0);
        op(0, BCC_CMD_DISOWN_WRITE, mk(12'h007, 12'h005));
        chk("dma own inval", inv_s, 1);
        xfer(0, 1, mk(12'h007, 12'h005), 0);
        op(0, BCC_CMD_OWN_READ, mk(12'h007, 12'h005));
    endtask
    task automatic t_regs();
        xfer(2, 1, TAGR + 32'h0000_013F, 32'hC000_0123);
        xfer(2, 0, TAGR + 32'h0000_0120, 0);
        chk("tag reg", rd_v, 32'hC000_0123);
        ops(0);
        xfer(0, 1, mk(12'h123, 12'h009), 0);
        ops(0);
        xfer(2, 1, DEAL + 32'h0000_0125, 0);
        op(0, BCC_CMD_DISOWN_WRITE, mk(12'h123, 12'h009));
        chk("dealloc inval", inv_s, 1);
        xfer(2, 0, TAGR + 32'h0000_0120, 0);
        chk("tag gone", rd_v[31:30], 2'h0);
        xfer(2, 0, 32'h0000_0010, 0);
        op(0, BCC_CMD_IO_READ, 32'hE100_0010);
        chk("io data", rd_v, 32'hDA7A_0010);
        xfer(2, 1, 32'h0000_00FF, 32'h1234_5678);
        op(0, BCC_CMD_IO_WRITE, 32'hE100_00FF);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_disabled();
        t_control();
        mem.delay = 3;
        t_fill();
        t_victim();
        mem.delay = 0;
        t_dma();
        t_regs();
        print_verdict();
    end
endmodule // testbench
